// File: verilog/sfcr_top.sv
// Configuration registers 0 to 3 with the serial command port
// Notes on behaviour
// - Clock control holds a four-bit divider code 0..15 in its low bits.
// - Operating clock is system clock divided by code plus one.
// - Gain register: second amp gain in 7:4, reserved 3:2, first amp in 1:0.
// - Offset trim: bit 7 sign, one positive; bits 6:0 magnitude.
// - Magnitude applies as count of 128ths of reference span, polarity by sign.
// - Bias code in 6:4; codes 0..3 step up, top bit set gives highest.
// - Read command 0x2N, then a dummy byte returning register N.
// - Write command 0x4N, then data bytes; address advances after each byte.
`timescale 1ns/1ps
`default_nettype none
module sfcr_top
(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       spi_sel_n,
  input  wire logic       spi_sck,
  input  wire logic       spi_mosi,
  output logic            spi_miso,
  output logic            spi_miso_oe,
  output logic            opclk_en,
  output logic [3:0]      div_opclk_code,
  output logic [3:0]      second_amp_gain_code,
  output logic [1:0]      first_amp_gain_code,
  output logic            offset_sign,
  output logic [6:0]      offset_trim_code,
  output logic [7:0]      offset_comp,
  output logic [2:0]      adc_bias_code,
  output logic [2:0]      adc_bias_level,
  output logic [1:0]      adc_vrt_code,
  output logic [1:0]      adc_vrb_code
);
  sfcr_cfg_if cfg ();

  sfcr_pkg::sfcr_state_e state_reg;
  logic [7:0] reg_file_reg [0:3];
  logic [3:0] addr_reg;
  logic [2:0] bit_cnt_reg;
  logic [7:0] rx_reg;
  logic [7:0] tx_reg;
  logic       sck_prev_reg;
  logic       loaded_reg;
  logic       sck_rise;
  logic       sck_fall;
  logic       byte_done;
  logic [7:0] rx_byte;
  logic [3:0] rx_cmd;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic reg_hit(input logic [3:0] a);
    reg_hit = (a <= sfcr_pkg::REG_LAST);
  endfunction : reg_hit

  function automatic logic [7:0] reg_mask(input logic [3:0] a);
    case (a)
      sfcr_pkg::ADDR_CLK:  reg_mask = sfcr_pkg::CLK_MASK;
      sfcr_pkg::ADDR_PGA:  reg_mask = sfcr_pkg::PGA_MASK;
      sfcr_pkg::ADDR_DCOC: reg_mask = sfcr_pkg::DCOC_MASK;
      sfcr_pkg::ADDR_ADC:  reg_mask = sfcr_pkg::ADC_MASK;
      default:             reg_mask = 8'h00;
    endcase
  endfunction : reg_mask

  function automatic logic [7:0] read_value(input logic [3:0] a);
    if (reg_hit(a))
      read_value = reg_file_reg[a[1:0]] & reg_mask(a);
    else
      read_value = 8'h00;
  endfunction : read_value

  // ****************************************
  // Serial byte engine
  // ****************************************
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      sck_prev_reg <= 1'b0;
    else
      sck_prev_reg <= spi_sck;
  end

  assign sck_rise  = !spi_sel_n && spi_sck && !sck_prev_reg;
  assign sck_fall  = !spi_sel_n && !spi_sck && sck_prev_reg;
  assign byte_done = sck_rise && (bit_cnt_reg == sfcr_pkg::BIT_LAST);
  assign rx_byte   = {rx_reg[6:0], spi_mosi};
  assign rx_cmd    = rx_byte[sfcr_pkg::CMD_MSB:sfcr_pkg::CMD_LSB];

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      bit_cnt_reg <= 3'h0;
      rx_reg      <= 8'h00;
    end
    else if (spi_sel_n)
      bit_cnt_reg <= 3'h0;
    else if (sck_rise)
    begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      rx_reg      <= rx_byte;
    end
  end

  // ****************************************
  // Command sequencer
  // ****************************************
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      state_reg <= sfcr_pkg::SFCR_ST_CMD;
    else if (spi_sel_n)
      state_reg <= sfcr_pkg::SFCR_ST_CMD;
    else if (byte_done)
    begin
      case (state_reg)
        sfcr_pkg::SFCR_ST_CMD:
          if (rx_cmd == sfcr_pkg::CMD_READ)
            state_reg <= sfcr_pkg::SFCR_ST_RDATA;
          else if (rx_cmd == sfcr_pkg::CMD_WRITE)
            state_reg <= sfcr_pkg::SFCR_ST_WDATA;
          else
            state_reg <= sfcr_pkg::SFCR_ST_CMD;
        sfcr_pkg::SFCR_ST_RDATA: state_reg <= sfcr_pkg::SFCR_ST_CMD;
        sfcr_pkg::SFCR_ST_WDATA: state_reg <= sfcr_pkg::SFCR_ST_WDATA;
        default:                 state_reg <= sfcr_pkg::SFCR_ST_CMD;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      addr_reg <= 4'h0;
    else if (byte_done && (state_reg == sfcr_pkg::SFCR_ST_CMD))
      addr_reg <= rx_byte[sfcr_pkg::NADDR_MSB:0];
    else if (byte_done && (state_reg == sfcr_pkg::SFCR_ST_WDATA))
      addr_reg <= addr_reg + 4'h1;
  end

  // ****************************************
  // Register storage
  // ****************************************
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      reg_file_reg[0] <= sfcr_pkg::CLK_RST;
      reg_file_reg[1] <= sfcr_pkg::PGA_RST;
      reg_file_reg[2] <= sfcr_pkg::DCOC_RST;
      reg_file_reg[3] <= sfcr_pkg::ADC_RST;
    end
    else if (byte_done && (state_reg == sfcr_pkg::SFCR_ST_WDATA)
             && reg_hit(addr_reg))
      reg_file_reg[addr_reg[1:0]] <= rx_byte & reg_mask(addr_reg);
  end

  // ****************************************
  // Return data, shifted out on falling edges
  // ****************************************
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tx_reg     <= sfcr_pkg::STATUS_BYTE;
      loaded_reg <= 1'b0;
    end
    else if (spi_sel_n)
    begin
      tx_reg     <= sfcr_pkg::STATUS_BYTE;
      loaded_reg <= 1'b0;
    end
    else if (byte_done)
    begin
      loaded_reg <= 1'b1;
      if ((state_reg == sfcr_pkg::SFCR_ST_CMD)
          && (rx_cmd == sfcr_pkg::CMD_READ))
        tx_reg <= read_value(rx_byte[sfcr_pkg::NADDR_MSB:0]);
      else
        tx_reg <= sfcr_pkg::STATUS_BYTE;
    end
    else if (sck_fall)
    begin
      loaded_reg <= 1'b0;
      if (!loaded_reg)
        tx_reg <= {tx_reg[6:0], 1'b0};
    end
  end

  assign spi_miso    = tx_reg[7];
  assign spi_miso_oe = !spi_sel_n;

  // ****************************************
  // Decoded settings
  // ****************************************
  assign cfg.div_code           = reg_file_reg[0][sfcr_pkg::DIV_MSB:0];
  assign div_opclk_code         = cfg.div_code;
  assign opclk_en               = cfg.opclk_en;
  assign second_amp_gain_code   =
    reg_file_reg[1][sfcr_pkg::PGA2_MSB:sfcr_pkg::PGA2_LSB];
  assign first_amp_gain_code    = reg_file_reg[1][sfcr_pkg::PGA1_MSB:0];
  assign offset_sign            = reg_file_reg[2][sfcr_pkg::SIGN_BIT];
  assign offset_trim_code       = reg_file_reg[2][sfcr_pkg::MAG_MSB:0];
  // Signed compensation in 128ths of the reference span
  assign offset_comp = offset_sign ? {1'b0, offset_trim_code}
                                   : 8'h00 - {1'b0, offset_trim_code};
  assign adc_bias_code =
    reg_file_reg[3][sfcr_pkg::BIAS_MSB:sfcr_pkg::BIAS_LSB];
  assign adc_bias_level = adc_bias_code[2] ? sfcr_pkg::BIAS_TOP
                                           : adc_bias_code;
  assign adc_vrt_code =
    reg_file_reg[3][sfcr_pkg::VRT_MSB:sfcr_pkg::VRT_LSB];
  assign adc_vrb_code = reg_file_reg[3][sfcr_pkg::VRB_MSB:0];

  sfcr_opclk_div u_div
  (
    .clk  (clk),
    .rstn (rstn),
    .cfg  (cfg.div)
  );

  // ****************************************
  // Checks
  // ****************************************
  property p_clk_write;
    @(posedge clk) disable iff (!rstn)
    byte_done && (state_reg == sfcr_pkg::SFCR_ST_WDATA)
      && (addr_reg == sfcr_pkg::ADDR_CLK)
      |=> div_opclk_code == $past(rx_byte[3:0]);
  endproperty
  a_clk_write: assert property (p_clk_write)
    else $error("Divider code not taken from written byte");

  property p_pga_write;
    @(posedge clk) disable iff (!rstn)
    byte_done && (state_reg == sfcr_pkg::SFCR_ST_WDATA)
      && (addr_reg == sfcr_pkg::ADDR_PGA)
      |=> (second_amp_gain_code == $past(rx_byte[7:4]))
          && (first_amp_gain_code == $past(rx_byte[1:0]))
          && (reg_file_reg[1][3:2] == 2'h0);
  endproperty
  a_pga_write: assert property (p_pga_write)
    else $error("Gain fields not placed as expected");

  property p_offset_write;
    @(posedge clk) disable iff (!rstn)
    byte_done && (state_reg == sfcr_pkg::SFCR_ST_WDATA)
      && (addr_reg == sfcr_pkg::ADDR_DCOC)
      |=> (offset_sign == $past(rx_byte[7]))
          && (offset_trim_code == $past(rx_byte[6:0]));
  endproperty
  a_offset_write: assert property (p_offset_write)
    else $error("Offset sign or magnitude wrong after write");

  property p_offset_comp;
    @(posedge clk) disable iff (!rstn)
    !offset_sign |-> (offset_comp + {1'b0, offset_trim_code}) == 8'h00;
  endproperty
  a_offset_comp: assert property (p_offset_comp)
    else $error("Negative compensation has wrong polarity");

  property p_bias_top;
    @(posedge clk) disable iff (!rstn)
    adc_bias_code[2] |-> adc_bias_level == 3'h4;
  endproperty
  a_bias_top: assert property (p_bias_top)
    else $error("High bias code not at highest setting");

  property p_read_data;
    @(posedge clk) disable iff (!rstn)
    byte_done && (state_reg == sfcr_pkg::SFCR_ST_CMD)
      && (rx_cmd == sfcr_pkg::CMD_READ) && (rx_byte[3:0] == 4'h1)
      |=> (tx_reg == (reg_file_reg[1] & 8'hf3))
          && (state_reg == sfcr_pkg::SFCR_ST_RDATA);
  endproperty
  a_read_data: assert property (p_read_data)
    else $error("Read command did not load register content");

  property p_addr_step;
    @(posedge clk) disable iff (!rstn)
    byte_done && (state_reg == sfcr_pkg::SFCR_ST_WDATA)
      |=> addr_reg == $past(addr_reg) + 4'h1;
  endproperty
  a_addr_step: assert property (p_addr_step)
    else $error("Write address did not advance by one");

  property p_reserved_zero;
    @(posedge clk) disable iff (!rstn)
    (reg_file_reg[0][7:4] == 4'h0) && (reg_file_reg[3][7] == 1'b0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("Unused bit was stored");

  c_read: cover property (@(posedge clk) disable iff (!rstn)
    byte_done && (state_reg == sfcr_pkg::SFCR_ST_RDATA));
  c_burst: cover property (@(posedge clk) disable iff (!rstn)
    byte_done && (state_reg == sfcr_pkg::SFCR_ST_WDATA)
      && (addr_reg == sfcr_pkg::ADDR_ADC));
  c_neg_offset: cover property (@(posedge clk) disable iff (!rstn)
    !offset_sign && (offset_trim_code == 7'h7f));
endmodule : sfcr_top
`default_nettype wire

// File: verilog/sfcr_pkg.sv
// Constants and types for the sensor front-end configuration registers
`default_nettype none
package sfcr_pkg;
  // ****************************************
  // Register indices
  // ****************************************
  localparam logic [3:0] ADDR_CLK  = 4'h0;
  localparam logic [3:0] ADDR_PGA  = 4'h1;
  localparam logic [3:0] ADDR_DCOC = 4'h2;
  localparam logic [3:0] ADDR_ADC  = 4'h3;
  localparam logic [3:0] REG_LAST  = ADDR_ADC;

  // ****************************************
  // Writable bit masks and reset values
  // ****************************************
  localparam logic [7:0] CLK_MASK  = 8'h0f;
  localparam logic [7:0] PGA_MASK  = 8'hf3;
  localparam logic [7:0] DCOC_MASK = 8'hff;
  localparam logic [7:0] ADC_MASK  = 8'h7f;
  localparam logic [7:0] CLK_RST   = 8'h00;
  localparam logic [7:0] PGA_RST   = 8'h40;
  localparam logic [7:0] DCOC_RST  = 8'h00;
  localparam logic [7:0] ADC_RST   = 8'h25;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int DIV_MSB   = 3;
  localparam int PGA2_MSB  = 7;
  localparam int PGA2_LSB  = 4;
  localparam int PGA1_MSB  = 1;
  localparam int SIGN_BIT  = 7;
  localparam int MAG_MSB   = 6;
  localparam int BIAS_MSB  = 6;
  localparam int BIAS_LSB  = 4;
  localparam int VRT_MSB   = 3;
  localparam int VRT_LSB   = 2;
  localparam int VRB_MSB   = 1;
  localparam int CMD_MSB   = 7;
  localparam int CMD_LSB   = 4;
  localparam int NADDR_MSB = 3;

  // ****************************************
  // Commands, codes and states
  // ****************************************
  localparam logic [3:0] CMD_READ    = 4'h2;
  localparam logic [3:0] CMD_WRITE   = 4'h4;
  localparam logic [7:0] STATUS_BYTE = 8'h00;
  localparam logic [2:0] BIAS_TOP    = 3'h4;
  localparam logic [2:0] BIT_LAST    = 3'h7;

  typedef enum logic [2:0]
  {
    SFCR_ST_CMD   = 3'b001,
    SFCR_ST_RDATA = 3'b010,
    SFCR_ST_WDATA = 3'b100
  } sfcr_state_e;
endpackage : sfcr_pkg
`default_nettype wire

// File: verilog/sfcr_cfg_if.sv
// Divider code and operating-clock enable between register bank and divider
`timescale 1ns/1ps
`default_nettype none
interface sfcr_cfg_if;
  logic [3:0] div_code;
  logic       opclk_en;
  modport regs (output div_code, input opclk_en);
  modport div  (input div_code, output opclk_en);
endinterface : sfcr_cfg_if
`default_nettype wire

// File: verilog/sfcr_opclk_div.sv
// Operating-clock enable divider
`timescale 1ns/1ps
`default_nettype none
module sfcr_opclk_div
(
  input  wire logic clk,
  input  wire logic rstn,
  sfcr_cfg_if.div   cfg
);
  logic [3:0] cnt_reg;
  logic [3:0] div_prev_reg;
  logic [3:0] gap_reg;
  logic       chg_reg;

  // ****************************************
  // Divide by code plus one
  // ****************************************
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      div_prev_reg <= 4'h0;
    else
      div_prev_reg <= cfg.div_code;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      cnt_reg <= 4'h0;
    else if (cfg.div_code != div_prev_reg)
      cnt_reg <= 4'h0;
    else if (cnt_reg >= cfg.div_code)
      cnt_reg <= 4'h0;
    else
      cnt_reg <= cnt_reg + 4'h1;
  end

  assign cfg.opclk_en = (cnt_reg == cfg.div_code);

  // ****************************************
  // Checks
  // ****************************************
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      gap_reg <= 4'h0;
    else if (cfg.opclk_en)
      gap_reg <= 4'h0;
    else
      gap_reg <= gap_reg + 4'h1;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      chg_reg <= 1'b1;
    else if (cfg.div_code != div_prev_reg)
      chg_reg <= 1'b1;
    else if (cfg.opclk_en)
      chg_reg <= 1'b0;
  end

  property p_div_pass;
    @(posedge clk) disable iff (!rstn)
    (cfg.div_code == 4'h0) && $stable(cfg.div_code) |-> cfg.opclk_en;
  endproperty
  a_div_pass: assert property (p_div_pass)
    else $error("Code zero did not pass the clock through");

  property p_div_gap;
    @(posedge clk) disable iff (!rstn)
    cfg.opclk_en && !chg_reg && (cfg.div_code == div_prev_reg)
      |-> gap_reg == cfg.div_code;
  endproperty
  a_div_gap: assert property (p_div_gap)
    else $error("Operating clock period is not code plus one");

  c_div_max: cover property (@(posedge clk) disable iff (!rstn)
    cfg.opclk_en && (cfg.div_code == 4'hf) && !chg_reg);
endmodule : sfcr_opclk_div
`default_nettype wire

// File: test/sfcr_spi_host.sv
// Serial command master model driving the configuration port
`timescale 1ns/1ps
`default_nettype none
module sfcr_spi_host
#(
  parameter int HALF = 4
)
(
  input  wire logic clk,
  output logic      spi_sel_n,
  output logic      spi_sck,
  output logic      spi_mosi,
  input  wire logic spi_miso
);
  initial
  begin
    spi_sel_n = 1'b1;
    spi_sck   = 1'b0;
    spi_mosi  = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_clk

  // Select for a new frame
  task automatic open_frame();
    @(posedge clk);
    spi_sel_n <= 1'b0;
    wait_clk(HALF);
  endtask : open_frame

  // Release; a released data line flips level
  task automatic close_frame();
    @(posedge clk);
    spi_sel_n <= 1'b1;
    spi_mosi  <= ~spi_mosi;
    wait_clk(HALF);
  endtask : close_frame

  // Leading n bits, mode 0, MSB first; reply sampled at each rise
  task automatic bits(input logic [7:0] tx, input int n,
                      output logic [7:0] rx);
    for (int i = 7; i > 7 - n; i--)
    begin
      spi_mosi <= tx[i];
      wait_clk(HALF);
      rx[i] = spi_miso;
      spi_sck <= 1'b1;
      wait_clk(HALF);
      spi_sck <= 1'b0;
    end
  endtask : bits

  // One whole byte
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    bits(tx, 8, rx);
  endtask : xfer
endmodule : sfcr_spi_host
`default_nettype wire

// File: test/sfcr_top_tb.sv
// Self-checking bench for the configuration register bank
`timescale 1ns/1ps
`default_nettype none
module sfcr_top_tb;
  logic       clk = 1'b0;
  logic       rstn = 1'b0;
  logic       sel_n, sck, mosi, miso, miso_oe, opclk_en, sign;
  logic [3:0] div_code, gain2;
  logic [1:0] gain1, vrt, vrb;
  logic [6:0] mag;
  logic [7:0] comp;
  logic [2:0] bias, bias_lvl;
  int         n_errors = 0;
  int         samples_checked = 0;

  always #50 clk = ~clk;

  sfcr_spi_host host
  (
    .clk       (clk),
    .spi_sel_n (sel_n),
    .spi_sck   (sck),
    .spi_mosi  (mosi),
    .spi_miso  (miso)
  );

  sfcr_top dut
  (
    .clk                  (clk),
    .rstn                 (rstn),
    .spi_sel_n            (sel_n),
    .spi_sck              (sck),
    .spi_mosi             (mosi),
    .spi_miso             (miso),
    .spi_miso_oe          (miso_oe),
    .opclk_en             (opclk_en),
    .div_opclk_code       (div_code),
    .second_amp_gain_code (gain2),
    .first_amp_gain_code  (gain1),
    .offset_sign          (sign),
    .offset_trim_code     (mag),
    .offset_comp          (comp),
    .adc_bias_code        (bias),
    .adc_bias_level       (bias_lvl),
    .adc_vrt_code         (vrt),
    .adc_vrb_code         (vrb)
  );

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    logic [7:0] st;
    host.open_frame();
    host.xfer({sfcr_pkg::CMD_READ, a}, st);
    host.xfer(8'h00, d);
    host.close_frame();
  endtask : rd

  task automatic wr(input logic [3:0] a, input logic [7:0] d[$]);
    logic [7:0] st;
    host.open_frame();
    host.xfer({sfcr_pkg::CMD_WRITE, a}, st);
    foreach (d[i]) host.xfer(d[i], st);
    host.close_frame();
  endtask : wr

  task automatic complete_run();
    $display("Checked %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    logic [7:0] d;
    logic [7:0] exp [4] = '{8'h00, 8'h40, 8'h00, 8'h25};
    check({7'h0, miso_oe}, 8'h00, "oe idle");
    for (int i = 0; i < 4; i++)
    begin
      rd(i[3:0], d);
      check(d, exp[i], "reset value");
    end
    check({4'h0, gain2}, 8'h04, "gain2");
    check({6'h0, gain1}, 8'h00, "gain1");
    check({5'h0, bias_lvl}, 8'h02, "bias level");
    check({4'h0, vrt, vrb}, 8'h05, "refs");
    check({7'h0, opclk_en}, 8'h01, "opclk code zero");
    $display("test reset done");
  endtask : t_reset

  task automatic t_burst();
    logic [7:0] d;
    logic [7:0] exp [4] = '{8'h0f, 8'hf3, 8'hff, 8'h7f};
    wr(4'h0, '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff});
    for (int i = 0; i < 4; i++)
    begin
      rd(i[3:0], d);
      check(d, exp[i], "burst readback");
    end
    check({4'h0, div_code}, 8'h0f, "div code");
    check({gain2, 2'h0, gain1}, 8'hf3, "gains");
    check({sign, mag}, 8'hff, "trim fields");
    check(comp, 8'h7f, "comp max");
    check({bias, bias_lvl, 2'h0}, 8'hf0, "bias top");
    $display("test burst done");
  endtask : t_burst

  task automatic t_cascade();
    logic [7:0] d;
    host.open_frame();
    check({7'h0, miso_oe}, 8'h01, "oe selected");
    host.xfer(8'h10, d);
    host.xfer(8'h21, d);
    host.xfer(8'h00, d);
    check(d, 8'hf3, "after unknown cmd");
    host.xfer(8'h25, d);
    host.xfer(8'h00, d);
    check(d, 8'h00, "unmapped read");
    host.xfer(8'h23, d);
    host.xfer(8'h00, d);
    check(d, 8'h7f, "cascaded read");
    host.close_frame();
    $display("test cascade done");
  endtask : t_cascade

  task automatic t_offset();
    logic [7:0] v [4] = '{8'h05, 8'h85, 8'h00, 8'h7f};
    logic [7:0] m;
    for (int i = 0; i < 4; i++)
    begin
      wr(4'h2, '{v[i]});
      m = {1'b0, v[i][6:0]};
      check({sign, mag}, v[i], "trim fields");
      check(comp, v[i][7] ? m : 8'h00 - m, "comp");
    end
    $display("test offset done");
  endtask : t_offset

  task automatic t_bias();
    logic [2:0] b;
    for (int c = 0; c < 8; c++)
    begin
      b = c[2:0];
      wr(4'h3, '{{1'b0, b, 4'h5}});
      check({5'h0, bias}, {5'h0, b}, "bias code");
      check({5'h0, bias_lvl}, b[2] ? 8'h04 : {5'h0, b}, "bias lvl");
    end
    $display("test bias done");
  endtask : t_bias

  task automatic t_div();
    logic [3:0] codes [4] = '{4'h0, 4'h1, 4'h3, 4'hf};
    logic [7:0] cnt;
    for (int i = 0; i < 4; i++)
    begin
      wr(4'h0, '{{4'h0, codes[i]}});
      check({4'h0, div_code}, {4'h0, codes[i]}, "div code");
      cnt = 8'h00;
      repeat (48)
      begin
        @(posedge clk);
        cnt = cnt + {7'h0, opclk_en};
      end
      check(cnt, 8'(48 / (codes[i] + 1)), "opclk pulses");
    end
    $display("test divider done");
  endtask : t_div

  task automatic t_cut();
    logic [7:0] d;
    host.open_frame();
    host.xfer({sfcr_pkg::CMD_WRITE, 4'h1}, d);
    host.bits(8'h00, 4, d);
    host.close_frame();
    host.open_frame();
    host.bits({sfcr_pkg::CMD_READ, 4'h0}, 5, d);
    host.close_frame();
    rd(4'h1, d);
    check(d, 8'hf3, "after cut write");
    rd(4'h0, d);
    check(d, 8'h0f, "after cut command");
    rstn <= 1'b0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_reset();
    $display("test cut done");
  endtask : t_cut

  initial
  begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_burst();
    t_cascade();
    t_offset();
    t_bias();
    t_div();
    t_cut();
    complete_run();
  end

  initial
  begin
    repeat (60000) @(posedge clk);
    n_errors++;
    $display("BAD %0t watchdog expired", $time);
    complete_run();
  end
endmodule : sfcr_top_tb
`default_nettype wire
